// ==== hw/ctsf_pkg.sv ====
// Constants, types and register map of the transceiver status flag block
package ctsf_pkg;

  localparam int unsigned CLK_HZ              = 10_000_000;
  localparam int unsigned UV_FILTER_TIME_US   = 100;
  localparam int unsigned UV_FILTER_CYCLES    = (UV_FILTER_TIME_US * CLK_HZ) / 1_000_000;
  localparam int unsigned GO_TO_SLEEP_TIME_US = 50;
  localparam int unsigned GO_TO_SLEEP_CYCLES  = (GO_TO_SLEEP_TIME_US * CLK_HZ) / 1_000_000;
  localparam int unsigned CNT_W               = 12;
  localparam logic [CNT_W-1:0] UV_FILTER_LAST = CNT_W'(UV_FILTER_CYCLES - 1);
  localparam logic [CNT_W-1:0] GTS_LAST       = CNT_W'(GO_TO_SLEEP_CYCLES - 1);
  localparam logic [2:0] TXD_EDGES_TO_CLEAR   = 3'h4;

  localparam int unsigned ADDR_W              = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam int unsigned CTRL_MASK_BIT       = 0;
  localparam logic CTRL_MASK_RESET            = 1'h0;

  localparam logic [1:0] RESP_OKAY            = 2'h0;
  localparam logic [1:0] RESP_SLVERR          = 2'h2;

  localparam int unsigned NUM_SUPPLIES        = 2;

  typedef enum logic [4:0] {
    MODE_NORMAL      = 5'h01,
    MODE_SILENT      = 5'h02,
    MODE_STANDBY     = 5'h04,
    MODE_GO_TO_SLEEP = 5'h08,
    MODE_SLEEP       = 5'h10
  } ctsf_mode_t;

  localparam ctsf_mode_t MODE_RESET = MODE_STANDBY;

  typedef struct packed {
    logic mask_change_flag;
    logic wake_source_local;
    logic wake_source_flag;
    logic wake_request_flag;
    logic cold_start_flag;
  } ctsf_flags_t;

  // Power-up is a cold start: local wake recorded with it
  localparam ctsf_flags_t FLAGS_RESET = 5'h0F;

endpackage : ctsf_pkg

// ==== hw/ctsf_status_flags.sv ====
// Status flag, mode and pin logic of the CAN transceiver with an AXI4-Lite view
//
// Summary of operation
// - A floating transmit-data input counts as recessive, never dominant.
// - In standby, go-to-sleep and sleep, receive-data is high once I/O supply valid, low on power-on or wake.
// - Shown flags are ORed onto fault_indicator_n; wake also pulls receive-data low.
// - Mode follows enable and standby_select_n; both read low when floating.
// - supply_control_out driven in all modes except sleep, released in sleep.
// - Local wake is either edge on the wake input.
// - cold_start_flag sets at power-up and on battery recovery from undervoltage.
// - cold_start_flag pulls fault low entering silent from standby or sleep; clears in normal.
// - A cold start also sets wake request and a local wake source.
// - With wake request set, standby drives fault and receive-data low.
// - Wake request sets on cold start in any mode, on wake only in standby, go-to-sleep, sleep; restarts undervoltage timers.
// - Wake request clears entering normal or on filtered supply undervoltage.
// - Go-to-sleep is blocked while wake request is set.
// - In normal, fault shows wake source: low local, high remote.
// - Wake source keeps the first source until it is cleared.
// - Wake source clears after four falling transmit edges, leaving normal, or undervoltage.
// - Mask change sets a flag shown in silent; clears entering other modes.
`timescale 1ns/10ps

module ctsf_status_flags
  import ctsf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              txd,
  input  wire logic              txd_floating,
  input  wire logic              enable_select,
  input  wire logic              enable_floating,
  input  wire logic              standby_select_n,
  input  wire logic              standby_floating,
  input  wire logic              wake_in,
  input  wire logic              remote_wake,
  input  wire logic              bus_rx,
  input  wire logic              vio_valid,
  input  wire logic              vsup_uv,
  input  wire logic              vcc_uv,
  input  wire logic              vio_uv,
  output logic                   rxd,
  output logic                   fault_indicator_n,
  output logic                   supply_control_out,
  output logic                   supply_control_oe_n
);

  // Bus slave state
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic              aw_full_q, w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic              mask_q;

  // Core state
  ctsf_mode_t        mode_q, mode_d;
  ctsf_flags_t       flags_q, flags_d;
  logic              wake_prev_q, txd_prev_q, vsup_uv_prev_q, from_low_q;
  logic [2:0]        txd_edges_q;
  logic [CNT_W-1:0]  gts_cnt_q;
  logic [NUM_SUPPLIES-1:0] uv_in, uv_evt;
  logic [CNT_W-1:0]  uv_cnt_q [NUM_SUPPLIES];
  logic              rxd_q, fault_n_q, inh_q, inh_oe_n_q;

  logic txd_eff, en_eff, stb_n_eff;
  logic do_write, mask_changed, local_evt, wake_evt, cold_evt, low_power_mode;
  logic mode_change, wr_set, wr_clr, ws_set, ws_clr, mc_set, mc_clr, uv_any, txd_fall;

  assign txd_eff   = txd | txd_floating;
  assign en_eff    = enable_select & ~enable_floating;
  assign stb_n_eff = standby_select_n & ~standby_floating;

  // ---------------- AXI4-Lite slave ----------------
  assign do_write     = aw_full_q & w_full_q & ~bvalid_q;
  assign mask_changed = do_write & (awaddr_q == CTRL_OFFSET) & wstrb_q[0]
                        & (wdata_q[CTRL_MASK_BIT] != mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (!aw_full_q && !bvalid_q && !awready_q) begin
        awready_q <= 1'b1;
      end else if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (!w_full_q && !bvalid_q && !wready_q) begin
        wready_q <= 1'b1;
      end else if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        if (awaddr_q == CTRL_OFFSET) begin
          bresp_q <= RESP_OKAY;
        end else if (awaddr_q == STATUS_OFFSET) begin
          bresp_q <= RESP_OKAY;
        end else begin
          bresp_q <= RESP_SLVERR;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= CTRL_MASK_RESET;
    end else if (do_write && awaddr_q == CTRL_OFFSET && wstrb_q[0]) begin
      mask_q <= wdata_q[CTRL_MASK_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (!rvalid_q && !arready_q) begin
        arready_q <= 1'b1;
      end else if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        if (s_axi_araddr == CTRL_OFFSET) begin
          rdata_q <= {31'h0, mask_q};
          rresp_q <= RESP_OKAY;
        end else if (s_axi_araddr == STATUS_OFFSET) begin
          rdata_q <= {19'h0, mode_q, 3'h0, flags_q};
          rresp_q <= RESP_OKAY;
        end else begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- Events ----------------
  assign low_power_mode = (mode_q == MODE_STANDBY) || (mode_q == MODE_GO_TO_SLEEP)
                          || (mode_q == MODE_SLEEP);
  assign local_evt = wake_in ^ wake_prev_q;
  assign wake_evt  = (local_evt | remote_wake) & low_power_mode;
  assign cold_evt  = vsup_uv_prev_q & ~vsup_uv;
  assign wr_set    = cold_evt | wake_evt;
  assign uv_in     = {vio_uv, vcc_uv};
  assign uv_any    = |uv_evt;
  assign txd_fall  = txd_prev_q & ~txd_eff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_prev_q    <= 1'b0;
      txd_prev_q     <= 1'b1;
      vsup_uv_prev_q <= 1'b0;
    end else begin
      wake_prev_q    <= wake_in;
      txd_prev_q     <= txd_eff;
      vsup_uv_prev_q <= vsup_uv;
    end
  end

  // Undervoltage filters, restarted by a new wake request
  for (genvar i = 0; i < NUM_SUPPLIES; i++) begin : g_uv
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        uv_cnt_q[i] <= '0;
      end else if (!uv_in[i] || wr_set) begin
        uv_cnt_q[i] <= '0;
      end else if (uv_cnt_q[i] != UV_FILTER_LAST) begin
        uv_cnt_q[i] <= uv_cnt_q[i] + CNT_W'(1);
      end
    end
    assign uv_evt[i] = uv_in[i] && !wr_set && (uv_cnt_q[i] == UV_FILTER_LAST - CNT_W'(1));
  end

  // ---------------- Mode selection ----------------
  always_comb begin
    mode_d = mode_q;
    if (mode_q == MODE_SLEEP && flags_q.wake_request_flag) begin
      mode_d = MODE_STANDBY;
    end else if (stb_n_eff && en_eff) begin
      mode_d = MODE_NORMAL;
    end else if (stb_n_eff) begin
      mode_d = MODE_SILENT;
    end else if (!en_eff) begin
      if (mode_q != MODE_SLEEP) begin
        mode_d = MODE_STANDBY;
      end
    end else if (mode_q == MODE_GO_TO_SLEEP) begin
      if (flags_q.wake_request_flag) begin
        mode_d = MODE_STANDBY;
      end else if (gts_cnt_q == GTS_LAST) begin
        mode_d = MODE_SLEEP;
      end
    end else if (mode_q != MODE_SLEEP && !flags_q.wake_request_flag) begin
      mode_d = MODE_GO_TO_SLEEP;
    end else if (mode_q != MODE_SLEEP) begin
      mode_d = MODE_STANDBY;
    end
  end

  assign mode_change = mode_d != mode_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gts_cnt_q <= '0;
    end else if (mode_q != MODE_GO_TO_SLEEP || mode_change) begin
      gts_cnt_q <= '0;
    end else if (gts_cnt_q != GTS_LAST) begin
      gts_cnt_q <= gts_cnt_q + CNT_W'(1);
    end
  end

  // Silent entered from standby or sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      from_low_q <= 1'b0;
    end else if (mode_change && mode_d == MODE_SILENT) begin
      from_low_q <= (mode_q == MODE_STANDBY) || (mode_q == MODE_SLEEP);
    end else if (mode_d != MODE_SILENT) begin
      from_low_q <= 1'b0;
    end
  end

  // ---------------- Flags ----------------
  assign wr_clr = (mode_change && mode_d == MODE_NORMAL) || uv_any;
  assign ws_clr = (mode_q == MODE_NORMAL && txd_fall && txd_edges_q == TXD_EDGES_TO_CLEAR - 3'h1)
                  || (mode_change && mode_q == MODE_NORMAL) || uv_any;
  assign ws_set = wr_set && (!flags_q.wake_source_flag || ws_clr);
  assign mc_set = mask_changed;
  assign mc_clr = mode_change && mode_d != MODE_SILENT;

  always_comb begin
    flags_d = flags_q;
    // Hardware set wins over any clear in the same cycle
    flags_d.cold_start_flag   = cold_evt
                                | (flags_q.cold_start_flag
                                   & ~(mode_change && mode_d == MODE_NORMAL));
    flags_d.wake_request_flag = wr_set | (flags_q.wake_request_flag & ~wr_clr);
    flags_d.wake_source_flag  = ws_set | (flags_q.wake_source_flag & ~ws_clr);
    if (ws_set) begin
      flags_d.wake_source_local = cold_evt | local_evt;
    end else if (ws_clr) begin
      flags_d.wake_source_local = 1'b0;
    end
    flags_d.mask_change_flag  = mc_set | (flags_q.mask_change_flag & ~mc_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_edges_q <= '0;
    end else if (mode_q != MODE_NORMAL || ws_clr) begin
      txd_edges_q <= '0;
    end else if (txd_fall) begin
      txd_edges_q <= txd_edges_q + 3'h1;
    end
  end

  // ---------------- Pin outputs ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_n_q <= 1'b1;
    end else begin
      // Any flag needing a low indication wins
      fault_n_q <= ~(
          (mode_q == MODE_SILENT && from_low_q && flags_q.cold_start_flag)
        | (mode_q == MODE_SILENT && flags_q.mask_change_flag)
        | (mode_q == MODE_STANDBY && flags_q.wake_request_flag)
        | (mode_q == MODE_NORMAL && flags_q.wake_source_flag
           && flags_q.wake_source_local));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q <= 1'b0;
    end else if (!vio_valid) begin
      rxd_q <= 1'b0;
    end else if (low_power_mode && flags_q.wake_request_flag) begin
      rxd_q <= 1'b0;
    end else if (mode_q == MODE_NORMAL || mode_q == MODE_SILENT) begin
      rxd_q <= bus_rx;
    end else begin
      rxd_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inh_q      <= 1'b1;
      inh_oe_n_q <= 1'b0;
    end else begin
      inh_q      <= mode_q != MODE_SLEEP;
      inh_oe_n_q <= mode_q == MODE_SLEEP;
    end
  end

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign rxd                 = rxd_q;
  assign fault_indicator_n   = fault_n_q;
  assign supply_control_out  = inh_q;
  assign supply_control_oe_n = inh_oe_n_q;

endmodule : ctsf_status_flags

// ==== sim/ctsf_ctrl_model.sv ====
// Controller side: mode pins and transmit edges, pins released on request
`timescale 1ns/10ps
module ctsf_ctrl_model (
  input  wire logic       aclk,
  input  wire logic [1:0] mode_req,
  input  wire logic       release_pins,
  input  wire logic       float_txd,
  input  wire logic       edge_go,
  input  wire logic [2:0] edge_n,
  output logic            txd,
  output logic            txd_floating,
  output logic            enable_select,
  output logic            enable_floating,
  output logic            standby_select_n,
  output logic            standby_floating
);
  logic [3:0] steps_q;
  initial begin
    {txd, steps_q, enable_select, standby_select_n} = 7'h40;
    {txd_floating, enable_floating, standby_floating} = 3'h0;
  end
  always @(posedge aclk) begin
    if (edge_go) steps_q <= {edge_n, 1'h0};
    else if (steps_q != 4'h0) steps_q <= steps_q - 4'h1;
    // Released pins toggle so no stale level is mistaken for a drive
    txd <= (release_pins || float_txd || steps_q != 4'h0) ? ~txd : 1'h1;
    txd_floating <= release_pins || float_txd;
    enable_floating <= release_pins;
    standby_floating <= release_pins;
    enable_select <= release_pins ? ~enable_select : mode_req[0];
    standby_select_n <= release_pins ? ~standby_select_n : mode_req[1];
  end
endmodule : ctsf_ctrl_model

// ==== sim/ctsf_status_flags_props.sv ====
// Handshake, pin and flag timing checks at the status flag block ports
`timescale 1ns/10ps
module ctsf_status_flags_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        enable_select,
  input wire logic        enable_floating,
  input wire logic        standby_select_n,
  input wire logic        standby_floating,
  input wire logic        wake_in,
  input wire logic        vio_valid,
  input wire logic        vcc_uv,
  input wire logic        vio_uv,
  input wire logic        rxd,
  input wire logic        fault_indicator_n,
  input wire logic        supply_control_out,
  input wire logic        supply_control_oe_n
);
  logic stby;
  assign stby = !standby_select_n && !enable_select && vio_valid && !supply_control_oe_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_supply_drive: assert property (
    !supply_control_oe_n |-> supply_control_out) else $error("supply driven off");
  chk_awake_supply: assert property (
    (standby_select_n && !standby_floating)[*3] |=> !supply_control_oe_n)
    else $error("supply released while awake");
  chk_standby_pair: assert property (
    stby[*3] |=> rxd == fault_indicator_n) else $error("rxd and fault disagree");
  chk_sleep_block: assert property (
    !standby_select_n && enable_select && !enable_floating && vio_valid && !rxd
    && !supply_control_oe_n |=> !supply_control_oe_n) else $error("sleep despite wake");
  chk_wake_edge: assert property (
    stby[*3] ##0 (!vcc_uv && !vio_uv && $changed(wake_in)) |-> ##[1:6] !rxd)
    else $error("local wake missed");
endmodule : ctsf_status_flags_props

bind ctsf_status_flags ctsf_status_flags_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .enable_select,
  .enable_floating, .standby_select_n, .standby_floating, .wake_in, .vio_valid, .vcc_uv,
  .vio_uv, .rxd, .fault_indicator_n, .supply_control_out, .supply_control_oe_n);

// ==== sim/tb.sv ====
// Self-checking bench of the transceiver status flag block
`timescale 1ns/10ps
module tb;
  import ctsf_pkg::*;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]        s_axi_wstrb;
  logic [2:0]        edge_n;
  logic [1:0]        s_axi_bresp, s_axi_rresp, mode_req, rsp;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, txd, txd_floating, enable_select, enable_floating, bus_rx;
  logic              standby_select_n, standby_floating, wake_in, remote_wake, vio_valid;
  logic              vsup_uv, vcc_uv, vio_uv, rxd, fault_indicator_n, supply_control_out;
  logic              supply_control_oe_n, release_pins, edge_go, float_txd;
  int                bad_count, samples_checked;

  ctsf_status_flags u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .txd, .txd_floating, .enable_select, .enable_floating,
    .standby_select_n, .standby_floating, .wake_in, .remote_wake, .bus_rx, .vio_valid,
    .vsup_uv, .vcc_uv, .vio_uv, .rxd, .fault_indicator_n, .supply_control_out,
    .supply_control_oe_n);
  ctsf_ctrl_model u_ctrl (.aclk, .mode_req, .release_pins, .float_txd, .edge_go, .edge_n, .txd,
    .txd_floating, .enable_select, .enable_floating, .standby_select_n, .standby_floating);

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_pin

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!(s_axi_bvalid === 1'h1 && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_rvalid === 1'h1 && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd

  function automatic logic [31:0] xs(input ctsf_mode_t m, input logic [4:0] f);
    return {19'h0, m, 3'h0, f};
  endfunction : xs

  task automatic st(input logic [31:0] e, input logic [31:0] msk);
    rd(STATUS_OFFSET, rdat, rsp);
    cmp_reg("status", e & msk, rdat & msk);
    cmp_reg("status_resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
  endtask : st

  task automatic go(input logic [1:0] m, input int c);
    mode_req <= m;
    cyc(c);
  endtask : go

  task automatic pulse(input logic [2:0] n, input logic rw);
    edge_n <= n;
    edge_go <= ~rw;
    remote_wake <= rw;
    cyc(1);
    {edge_go, remote_wake} <= 2'h0;
    cyc(12);
  endtask : pulse

  initial begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, wake_in, remote_wake, vsup_uv} = '0;
    {vcc_uv, vio_uv, mode_req, release_pins, edge_go, edge_n, float_txd} = '0;
    {bus_rx, vio_valid, s_axi_wstrb} = 6'h3F;
    {bad_count, samples_checked} = '0;
    cyc(16);
    aresetn <= 1'h1;
    cyc(4);
    cmp_pin("rxd", 1'h0, rxd);
    cmp_pin("fault", 1'h0, fault_indicator_n);
    cmp_pin("supply", 1'h1, supply_control_out);
    st(xs(MODE_STANDBY, FLAGS_RESET), '1);
    rd(CTRL_OFFSET, rdat, rsp);
    cmp_reg("ctrl", {31'h0, CTRL_MASK_RESET}, rdat);
    rd(4'h8, rdat, rsp);
    cmp_reg("bad_rd", {30'h0, RESP_SLVERR}, {rdat[29:0], rsp});
    wr(4'hC, 32'h1, rsp);
    cmp_reg("bad_wr", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    go(2'h2, 8);
    cmp_pin("fault", 1'h0, fault_indicator_n);
    st(xs(MODE_SILENT, 5'h0F), '1);
    go(2'h3, 8);
    cmp_pin("fault", 1'h0, fault_indicator_n);
    st(xs(MODE_NORMAL, 5'h0C), '1);
    bus_rx <= 1'h0;
    cyc(4);
    cmp_pin("rxd", 1'h0, rxd);
    bus_rx <= 1'h1;
    vio_valid <= 1'h0;
    cyc(4);
    cmp_pin("rxd_vio", 1'h0, rxd);
    vio_valid <= 1'h1;
    cyc(4);
    cmp_pin("rxd", 1'h1, rxd);
    pulse(3'h3, 1'h0);
    cmp_pin("fault", 1'h0, fault_indicator_n);
    pulse(3'h1, 1'h0);
    st(xs(MODE_NORMAL, 5'h00), '1);
    release_pins <= 1'h1;
    cyc(8);
    st(xs(MODE_STANDBY, 5'h00), '1);
    cmp_pin("fault", 1'h1, fault_indicator_n);
    release_pins <= 1'h0;
    go(2'h0, 4);
    wake_in <= 1'h1;
    cyc(8);
    cmp_pin("rxd", 1'h0, rxd);
    pulse(3'h0, 1'h1);
    st(xs(MODE_STANDBY, 5'h0E), '1);
    go(2'h1, GO_TO_SLEEP_CYCLES + 20);
    st(xs(MODE_STANDBY, 5'h0E), '1);
    go(2'h0, 4);
    go(2'h3, 8);
    go(2'h0, 8);
    pulse(3'h0, 1'h1);
    go(2'h3, 8);
    cmp_pin("fault", 1'h1, fault_indicator_n);
    st(xs(MODE_NORMAL, 5'h04), '1);
    float_txd <= 1'h1;
    cyc(10);
    float_txd <= 1'h0;
    st(xs(MODE_NORMAL, 5'h04), '1);
    cmp_pin("fault", 1'h1, fault_indicator_n);
    wr(CTRL_OFFSET, 32'h1, rsp);
    cmp_reg("wr_resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    go(2'h2, 8);
    cmp_pin("fault", 1'h0, fault_indicator_n);
    wr(STATUS_OFFSET, 32'hFFFF_FFFF, rsp);
    cmp_reg("ro_resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    st(xs(MODE_SILENT, 5'h10), '1);
    go(2'h3, 8);
    st(xs(MODE_NORMAL, 5'h00), '1);
    go(2'h0, 4);
    go(2'h1, GO_TO_SLEEP_CYCLES + 20);
    cmp_pin("sleep_oe_n", 1'h1, supply_control_oe_n);
    wake_in <= 1'h0;
    cyc(8);
    cmp_pin("wake_oe_n", 1'h0, supply_control_oe_n);
    go(2'h0, 4);
    vsup_uv <= 1'h1;
    cyc(UV_FILTER_CYCLES + 10);
    vsup_uv <= 1'h0;
    cyc(10);
    st(xs(MODE_STANDBY, 5'h0F), 32'h1F);
    vcc_uv <= 1'h1;
    cyc(UV_FILTER_CYCLES + 10);
    st(xs(MODE_STANDBY, 5'h01), 32'h0000_1F07);
    test_done;
  end

  initial begin
    cyc(8000);
    bad_count++;
    test_done;
  end
endmodule : tb
